/* File: inc/sspsi_pkg.sv */
// Constants for strap sampling and suspend indicator block
package sspsi_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 10;
    // Shortest reset pulse the system must apply
    localparam int unsigned RESET_MIN_NS      = 1000;
    localparam int unsigned RESET_MIN_CYCLES  =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES       = 2;
    localparam logic [1:0]  SETTLE_LAST       = 2'h2;

    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;

    localparam int unsigned CTRL_CONFIGURED   = 0;
    localparam int unsigned CTRL_SUSPENDED    = 1;
    localparam int unsigned CTRL_DYNAMIC      = 2;
    localparam int unsigned CTRL_ATTACH       = 3;
    localparam logic [3:0]  CTRL_RESET        = 4'h0;

    localparam int unsigned ST_CFG_MGMT       = 0;
    localparam int unsigned ST_STRAP_LO       = 1;
    localparam int unsigned ST_RESERVED       = 3;
    localparam int unsigned ST_SP_SAMPLED     = 4;
    localparam int unsigned ST_SP_REPORT      = 5;
    localparam int unsigned ST_SUSPEND_INDICATOR       = 6;
    localparam int unsigned ST_VALID          = 7;
    localparam int unsigned ST_FIXED_LO       = 8;

    localparam logic [1:0]  STRAP_NONE        = 2'h0;
    localparam logic [1:0]  STRAP_PORT1       = 2'h1;
    localparam logic [1:0]  STRAP_PORT12      = 2'h2;
    localparam logic [1:0]  STRAP_RESERVED    = 2'h3;
    localparam logic [1:0]  MASK_NONE         = 2'h0;
    localparam logic [1:0]  MASK_PORT1        = 2'h1;
    localparam logic [1:0]  MASK_PORT12       = 2'h3;

    typedef enum logic [0:0] {
        SSPSI_SETTLE = 1'b0,
        SSPSI_DONE   = 1'b1
    } sspsi_state_e;
endpackage : sspsi_pkg

/* File: inc/sspsi_strap_if.sv */
// Latched strap values and the live self-power level passed from the sampler to the core
`timescale 1ns/1ps
interface sspsi_strap_if;
    logic       straps_valid;
    logic       cfg_mgmt;
    logic [1:0] fixed_strap;
    logic       self_power_live;

    modport latch (output straps_valid, output cfg_mgmt,
                   output fixed_strap, output self_power_live);
    modport core  (input straps_valid, input cfg_mgmt,
                   input fixed_strap, input self_power_live);
endinterface : sspsi_strap_if

/* File: core/sspsi_strap_latch.sv */
// Pin synchronisers and strap capture after reset release
`timescale 1ns/1ps
module sspsi_strap_latch
    import sspsi_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     reset_n,
    input  wire logic     ce,
    input  wire logic     susp_pin_in,
    input  wire logic     mgmt_bus_data_pin,
    input  wire logic     mgmt_bus_clock_pin,
    sspsi_strap_if.latch  strap
);
    import sspsi_pkg::*;

    logic [2:0]   pins;
    logic [2:0]   sync1;
    logic [2:0]   sync2;
    sspsi_state_e state;
    sspsi_state_e next_state;
    logic [1:0]   cnt;
    logic [1:0]   next_cnt;
    logic         cfg_mgmt;
    logic         next_cfg_mgmt;
    logic [1:0]   fixed;
    logic [1:0]   next_fixed;

    assign pins = {mgmt_bus_clock_pin, mgmt_bus_data_pin, susp_pin_in};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
            end else if (ce) begin
                sync1[i] <= pins[i];
                sync2[i] <= sync1[i];
            end
        end
    end

    // Capture waits for the synchronisers to fill after release
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_cfg_mgmt = cfg_mgmt;
        next_fixed    = fixed;
        unique case (state)
            SSPSI_SETTLE: begin
                if (cnt == SETTLE_LAST) begin
                    next_state    = SSPSI_DONE;
                    next_cfg_mgmt = sync2[2];
                    next_fixed    = {sync2[1], sync2[0]};
                end else begin
                    next_cnt = cnt + 2'h1;
                end
            end
            SSPSI_DONE: begin
                next_state = SSPSI_DONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= SSPSI_SETTLE;
            cnt      <= 2'h0;
            cfg_mgmt <= 1'b0;
            fixed    <= STRAP_NONE;
        end else if (ce) begin
            state    <= next_state;
            cnt      <= next_cnt;
            cfg_mgmt <= next_cfg_mgmt;
            fixed    <= next_fixed;
        end
    end

    assign strap.straps_valid    = (state == SSPSI_DONE);
    assign strap.cfg_mgmt        = cfg_mgmt;
    assign strap.fixed_strap     = fixed;
    assign strap.self_power_live = sync2[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_settle;
        (!strap.straps_valid && ce) [*3];
    endsequence

    a_capture_bound: assert property (s_settle |=> strap.straps_valid)
        else $error("straps not captured after settle");
    a_strap_hold: assert property (strap.straps_valid |=>
        $stable(strap.fixed_strap) && $stable(strap.cfg_mgmt)
        && strap.straps_valid)
        else $error("latched strap changed");
endmodule : sspsi_strap_latch

/* File: core/sspsi_top.sv */
// Strap sampling and suspend/self-power pin block with APB registers
// How it works
// - The suspend indicator stays low when unconfigured or suspended.
// - The suspend indicator is high only when configured and active.
// - Under bus configuration the self-power level is sampled before attach.
// - After attach the self-power level is frozen.
// - Sampled low means bus powered, high means local power is present.
// - The sampled level picks the power report only with dynamic power set.
// - The shared pin is self-power input only under bus configuration.
// - The two-bit fixed-port strap is sampled at release and decoded.
// - The upper strap bit comes from the bus data pin at release.
// - The configuration method is latched from the bus clock pin.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sspsi_top
    import sspsi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        susp_pin_in,
    output logic             suspend_indicator,
    output logic             suspend_indicator_oe,
    input  wire logic        mgmt_bus_data_pin,
    input  wire logic        mgmt_bus_clock_pin,
    output logic             config_by_mgmt_bus,
    output logic [1:0]       fixed_port_mask,
    output logic             fixed_port_reserved,
    output logic             self_powered_report
);
    import sspsi_pkg::*;

    sspsi_strap_if strap ();

    logic [3:0]  ctrl;
    logic [3:0]  next_ctrl;
    logic        sp_sampled;
    logic        next_sp_sampled;
    logic        next_susp;
    logic        next_susp_oe;
    logic [1:0]  next_mask;
    logic        next_reserved;
    logic        next_report;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] status_word;
    logic        setup;
    logic        access;
    logic        mapped;

    sspsi_strap_latch u_latch (
        .clk                (clk),
        .reset_n            (reset_n),
        .ce                 (ce),
        .susp_pin_in        (susp_pin_in),
        .mgmt_bus_data_pin  (mgmt_bus_data_pin),
        .mgmt_bus_clock_pin (mgmt_bus_clock_pin),
        .strap              (strap)
    );

    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);

    always_comb begin
        status_word                  = 32'h0;
        status_word[ST_CFG_MGMT]     = config_by_mgmt_bus;
        status_word[ST_STRAP_LO+:2]  = strap.fixed_strap;
        status_word[ST_RESERVED]     = fixed_port_reserved;
        status_word[ST_SP_SAMPLED]   = sp_sampled;
        status_word[ST_SP_REPORT]    = self_powered_report;
        status_word[ST_SUSPEND_INDICATOR]     = suspend_indicator;
        status_word[ST_VALID]        = strap.straps_valid;
        status_word[ST_FIXED_LO+:2]  = fixed_port_mask;
    end

    // APB slave: no wait states, answer in the first access cycle
    always_comb begin
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        next_prdata  = 32'h0;
        next_ctrl    = ctrl;
        if (setup && !pwrite && paddr == ADDR_CTRL) begin
            next_prdata[3:0] = ctrl;
        end
        if (setup && !pwrite && paddr == ADDR_STATUS) begin
            next_prdata = status_word;
        end
        if (access && pwrite && paddr == ADDR_CTRL) begin
            next_ctrl = pwdata[3:0];
            // Attach is sticky so the frozen sample cannot be reopened
            next_ctrl[CTRL_ATTACH] = ctrl[CTRL_ATTACH]
                                     || pwdata[CTRL_ATTACH];
        end
    end

    always_comb begin
        next_sp_sampled = sp_sampled;
        if (strap.straps_valid && strap.cfg_mgmt
            && !ctrl[CTRL_ATTACH]) begin
            next_sp_sampled = strap.self_power_live;
        end
        next_susp    = 1'b0;
        next_susp_oe = 1'b0;
        // Pin is driven only in strap mode, once the strap has been read
        if (strap.straps_valid && !strap.cfg_mgmt) begin
            next_susp_oe = 1'b1;
            next_susp    = ctrl[CTRL_CONFIGURED]
                           && !ctrl[CTRL_SUSPENDED];
        end
        // Bus-configured hubs report self power unless dynamic
        next_report = 1'b1;
        if (strap.cfg_mgmt && ctrl[CTRL_DYNAMIC]) begin
            next_report = sp_sampled;
        end
        next_reserved = 1'b0;
        unique case (strap.fixed_strap)
            STRAP_NONE:   next_mask = MASK_NONE;
            STRAP_PORT1:  next_mask = MASK_PORT1;
            STRAP_PORT12: next_mask = MASK_PORT12;
            STRAP_RESERVED: begin
                next_mask     = MASK_NONE;
                next_reserved = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl                 <= CTRL_RESET;
            sp_sampled           <= 1'b0;
            suspend_indicator    <= 1'b0;
            suspend_indicator_oe <= 1'b0;
            config_by_mgmt_bus   <= 1'b0;
            fixed_port_mask      <= MASK_NONE;
            fixed_port_reserved  <= 1'b0;
            self_powered_report  <= 1'b1;
            prdata               <= 32'h0;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
        end else if (ce) begin
            ctrl                 <= next_ctrl;
            sp_sampled           <= next_sp_sampled;
            suspend_indicator    <= next_susp;
            suspend_indicator_oe <= next_susp_oe;
            config_by_mgmt_bus   <= strap.cfg_mgmt;
            fixed_port_mask      <= next_mask;
            fixed_port_reserved  <= next_reserved;
            self_powered_report  <= next_report;
            prdata               <= next_prdata;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_active;
        ce && strap.straps_valid && !strap.cfg_mgmt
        && ctrl[CTRL_CONFIGURED] && !ctrl[CTRL_SUSPENDED];
    endsequence

    a_susp_active: assert property (s_active |=>
        suspend_indicator && suspend_indicator_oe)
        else $error("suspend indicator not asserted when active");
    a_susp_idle: assert property ((ce && (!ctrl[CTRL_CONFIGURED]
        || ctrl[CTRL_SUSPENDED])) |=> !suspend_indicator)
        else $error("suspend indicator high while idle");
    a_mgmt_no_drive: assert property (config_by_mgmt_bus
        |-> !suspend_indicator_oe)
        else $error("shared pin driven under bus configuration");
    a_sample_frozen: assert property (ctrl[CTRL_ATTACH]
        |=> $stable(sp_sampled) && ctrl[CTRL_ATTACH])
        else $error("self power sample moved after attach");
    a_sample_track: assert property ((ce && strap.straps_valid
        && strap.cfg_mgmt && !ctrl[CTRL_ATTACH])
        |=> sp_sampled == $past(strap.self_power_live))
        else $error("self power not sampled before attach");
    a_report_bus: assert property ((ce && strap.cfg_mgmt
        && ctrl[CTRL_DYNAMIC] && !sp_sampled) |=> !self_powered_report)
        else $error("bus powered sample not reported");
    a_report_fixed: assert property ((ce && !ctrl[CTRL_DYNAMIC])
        |=> self_powered_report)
        else $error("report changed without dynamic power");
    a_decode_two: assert property ((ce
        && strap.fixed_strap == STRAP_PORT12)
        ##1 ce |=> fixed_port_mask == MASK_PORT12)
        else $error("strap 10 not decoded to ports 1 and 2");
    a_apb_answer: assert property ((setup && ce) |=> pready
        && pslverr == !$past(mapped))
        else $error("apb answer wrong");
endmodule : sspsi_top

/* File: bench/sspsi_board.sv */
// Board model: strap resistors, local power source and reset driver
`timescale 1ns/1ps
module sspsi_board
    import sspsi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       cfg_sel,
    input  wire logic [1:0] strap,
    input  wire logic       self_power_select,
    input  wire logic       drive_val,
    input  wire logic       drive_oe,
    output logic            reset_n,
    output logic            susp_pin,
    output logic            data_pin,
    output logic            clock_pin
);
    // Starts in reset; the first pulse from the bench reloads the count
    int unsigned cnt = RESET_MIN_CYCLES;

    // Pulse never shorter than the minimum low time
    always @(posedge clk) begin
        if (go) begin
            cnt <= RESET_MIN_CYCLES;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    // One driver only: reset follows the counter
    assign reset_n = (cnt == 0);

    // Hub drives the shared pin once it owns it, else the local power level under bus configuration or the strap resistor
    assign susp_pin  = drive_oe ? drive_val
                                : (cfg_sel ? self_power_select : strap[0]);
    assign data_pin  = strap[1];
    assign clock_pin = cfg_sel;
endmodule : sspsi_board

/* File: bench/tb_top.sv */
// Self-checking bench for the strap sampling and suspend pin block
`timescale 1ns/1ps
module tb_top;
    import sspsi_pkg::*;
    typedef struct packed {
        logic       cfg;
        logic [1:0] strap;
        logic [1:0] mask;
        logic       rsv;
    } sspsi_row_s;

    logic        clk, go, cfg_sel, self_power_select, reset_n, ce;
    logic        susp_pin, data_pin, clock_pin;
    logic [1:0]  strap, fixed_port_mask;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err, ind, ind_oe, cfg_out, rsv_out, report;
    int          fail_count, checked;
    sspsi_row_s  rows [5] = '{'{1'h0, 2'h0, MASK_NONE, 1'h0},
                              '{1'h0, 2'h1, MASK_PORT1, 1'h0},
                              '{1'h0, 2'h2, MASK_PORT12, 1'h0},
                              '{1'h0, 2'h3, MASK_NONE, 1'h1},
                              '{1'h1, 2'h2, MASK_PORT12, 1'h0}};
    // Status after a strap-mode reset with strap 01 and no hub activity
    localparam logic [31:0] STRAP_STATUS = (32'h1 << ST_VALID)
        | (32'h1 << ST_SP_REPORT) | (32'(STRAP_PORT1) << ST_STRAP_LO)
        | (32'(MASK_PORT1) << ST_FIXED_LO);

    initial clk = 1'b0;
    always #5 clk = ~clk;

    sspsi_board board (.clk(clk), .go(go), .cfg_sel(cfg_sel),
        .strap(strap), .self_power_select(self_power_select), .drive_val(ind),
        .drive_oe(ind_oe), .reset_n(reset_n), .susp_pin(susp_pin),
        .data_pin(data_pin), .clock_pin(clock_pin));

    sspsi_top dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .susp_pin_in(susp_pin),
        .suspend_indicator(ind), .suspend_indicator_oe(ind_oe),
        .mgmt_bus_data_pin(data_pin), .mgmt_bus_clock_pin(clock_pin),
        .config_by_mgmt_bus(cfg_out), .fixed_port_mask(fixed_port_mask),
        .fixed_port_reserved(rsv_out), .self_powered_report(report));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic timed_out(input string what);
        fail_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        summarize();
    endtask : timed_out

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    task automatic do_reset(input logic c, input logic [1:0] s,
                            input logic lp);
        int i;
        @(posedge clk);
        cfg_sel <= c;
        strap <= s;
        self_power_select <= lp;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cycles(2);
        for (i = 0; i < 400 && reset_n !== 1'b1; i++)
            @(posedge clk);
        if (reset_n !== 1'b1)
            timed_out("reset");
        // Strap outputs settle on the fourth edge after release
        cycles(6);
    endtask : do_reset

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50)
            timed_out("pready");
    endtask : apb

    initial begin
        {go, cfg_sel, strap, self_power_select, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        ce = 1'b1;
        fail_count = 0;
        checked = 0;
        foreach (rows[k]) begin
            do_reset(rows[k].cfg, rows[k].strap, 1'b0);
            for (int p = 0; p < 2; p++) begin
                chk("cfg", rows[k].cfg, cfg_out);
                chk("oe", !rows[k].cfg, ind_oe);
                chk("mask", rows[k].mask, fixed_port_mask);
                chk("rsv", rows[k].rsv, rsv_out);
                if (!rows[k].cfg) begin
                    chk("report", 1'b1, report);
                end
                // Flipped pins after capture must leave all latches alone
                cfg_sel <= ~rows[k].cfg;
                strap <= ~rows[k].strap;
                cycles(6);
            end
        end
        do_reset(1'b0, 2'h1, 1'b0);
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, ADDR_CTRL, 32'(v));
            cycles(3);
            chk("ind", v == 1, ind);
        end
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        chk("ctrl err", 1'b0, err);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", STRAP_STATUS, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("slverr", 1'b1, err);
        chk("rdata", 32'h0, rd);
        do_reset(1'b1, 2'h0, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        cycles(3);
        chk("report", 1'b1, report);
        apb(1'b1, ADDR_CTRL, 32'h4);
        cycles(3);
        chk("report", 1'b0, report);
        // Clock enable low must freeze the synchronisers and the sample
        ce <= 1'b0;
        self_power_select <= 1'b1;
        cycles(6);
        chk("ce frozen", 1'b0, report);
        ce <= 1'b1;
        cycles(6);
        chk("report", 1'b1, report);
        apb(1'b1, ADDR_CTRL, 32'hC);
        self_power_select <= 1'b0;
        cycles(6);
        chk("report", 1'b1, report);
        chk("oe", 1'b0, ind_oe);
        // Attach cannot be cleared by software
        apb(1'b1, ADDR_CTRL, 32'h4);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("attach", 32'hC, rd);
        // A fresh reset must clear the latched method
        go <= 1'b1;
        cycles(2);
        go <= 1'b0;
        chk("rst cfg", 1'b0, cfg_out);
        chk("rst report", 1'b1, report);
        summarize();
    end
endmodule : tb_top
